// [design/etls_top.sv]
// External torque limit selector with AXI4-Lite register file.
// Assumes contact inputs and torque/speed feedback synchronous to ref_clk.
//
// Decided for this implementation: the placing of the registers and the AXI4-Lite interface to the registers.
module etls_top
  import etls_pkg::*;
#(
  parameter int          TW         = 16,
  parameter logic [15:0] MAX_TORQUE = 16'h012C
) (
  input  wire logic          ref_clk,
  input  wire logic          rstn,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          fwd_ext_limit_in_n,
  input  wire logic          rev_ext_limit_in_n,
  input  wire logic          prop_control_in_n,
  input  wire logic [TW-1:0] torque_ref,
  input  wire logic [TW-1:0] motor_speed,
  output logic [TW-1:0]      fwd_torque_limit,
  output logic [TW-1:0]      rev_torque_limit,
  output logic               running_or_limit_out_n,
  output logic               p_control_out,
  output logic               preset_speed_active,
  output logic [1:0]         preset_speed_code,
  output logic [15:0]        preset_speed_ref,
  output logic               speed_dir_rev,
  output logic [15:0]        monitor_bit_word
);

  // ----------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------
  if (TW != 16) begin : g_bad_tw
    $error("etls_top: TW must be 16");
  end
  if (MAX_TORQUE == 16'h0000 || MAX_TORQUE[15]) begin : g_bad_max
    $error("etls_top: MAX_TORQUE out of range");
  end

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        aw_full;
    logic [7:0]  aw_addr;
    logic        w_full;
    logic [31:0] w_data;
    logic [3:0]  w_strb;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic [15:0] forward_external_torque_limit;
    logic [15:0] reverse_external_torque_limit;
    logic [15:0] memory_switch_one;
    logic [15:0] memory_switch_two;
    logic [15:0] fwd_int_limit;
    logic [15:0] rev_int_limit;
    logic [15:0] preset_speed_one_param;
    logic [15:0] preset_speed_two_param;
    logic [15:0] preset_speed_three_param;
    logic [15:0] run_level;
    logic [15:0] fwd_lim;
    logic [15:0] rev_lim;
    logic        out_n;
    logic        pctl;
    logic        spd_act;
    logic [1:0]  spd_code;
    logic [15:0] spd_ref;
    logic        dir_rev;
    logic [15:0] monitor;
  } etls_state_s;

  etls_state_s st_q;
  etls_state_s st_d;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic [15:0] etls_merge(input logic [15:0] old_v,
                                             input logic [31:0] wd,
                                             input logic [3:0]  ws);
    logic [15:0] v;
    v = old_v;
    if (ws[0]) begin
      v[7:0] = wd[7:0];
    end
    if (ws[1]) begin
      v[15:8] = wd[15:8];
    end
    return v;
  endfunction

  function automatic logic [15:0] etls_clamp(input logic [15:0] v);
    return (v > MAX_TORQUE) ? MAX_TORQUE : v;
  endfunction

  function automatic logic [15:0] etls_min(input logic [15:0] a, input logic [15:0] b);
    return (a < b) ? a : b;
  endfunction

  function automatic logic [15:0] etls_mag(input logic [15:0] v);
    return v[15] ? 16'(-v) : v;
  endfunction

  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  assign s_axi_awready = !st_q.aw_full && !st_q.bvalid;
  assign s_axi_wready  = !st_q.w_full && !st_q.bvalid;
  assign s_axi_arready = !st_q.rvalid;

  logic        csel;
  logic        fwd_on;
  logic        rev_on;
  logic        fwd_ext;
  logic        rev_ext;
  logic [15:0] fwd_eff;
  logic [15:0] rev_eff;
  logic [15:0] tq_mag;
  logic        limiting;
  logic        running;
  logic [1:0]  code;
  logic [15:0] wr_old;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    csel = st_q.memory_switch_two[ETLS_SW2_CSPEED_BIT];
    fwd_on = !fwd_ext_limit_in_n;
    rev_on = !rev_ext_limit_in_n;
    wr_old = 16'h0000;

    // Address and data capture in either order
    if (s_axi_awvalid && s_axi_awready) begin
      st_d.aw_full = 1'b1;
      st_d.aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      st_d.w_full = 1'b1;
      st_d.w_data = s_axi_wdata;
      st_d.w_strb = s_axi_wstrb;
    end

    // Register write
    if (st_q.aw_full && st_q.w_full && !st_q.bvalid) begin
      st_d.aw_full = 1'b0;
      st_d.w_full  = 1'b0;
      st_d.bvalid  = 1'b1;
      st_d.bresp   = ETLS_RESP_OKAY;
      case (st_q.aw_addr)
        ETLS_OFF_FWD_EXT: begin
          wr_old = etls_merge(st_q.forward_external_torque_limit, st_q.w_data, st_q.w_strb);
          st_d.forward_external_torque_limit = etls_clamp(wr_old);
        end
        ETLS_OFF_REV_EXT: begin
          wr_old = etls_merge(st_q.reverse_external_torque_limit, st_q.w_data, st_q.w_strb);
          st_d.reverse_external_torque_limit = etls_clamp(wr_old);
        end
        ETLS_OFF_MEM_SW1: begin
          st_d.memory_switch_one = etls_merge(st_q.memory_switch_one, st_q.w_data, st_q.w_strb);
        end
        ETLS_OFF_MEM_SW2: begin
          st_d.memory_switch_two = etls_merge(st_q.memory_switch_two, st_q.w_data, st_q.w_strb);
        end
        ETLS_OFF_FWD_INT: begin
          wr_old = etls_merge(st_q.fwd_int_limit, st_q.w_data, st_q.w_strb);
          st_d.fwd_int_limit = etls_clamp(wr_old);
        end
        ETLS_OFF_REV_INT: begin
          wr_old = etls_merge(st_q.rev_int_limit, st_q.w_data, st_q.w_strb);
          st_d.rev_int_limit = etls_clamp(wr_old);
        end
        ETLS_OFF_PRESET_SPEED_ONE: begin
          st_d.preset_speed_one_param = etls_merge(st_q.preset_speed_one_param, st_q.w_data, st_q.w_strb);
        end
        ETLS_OFF_PRESET_SPEED_TWO: begin
          st_d.preset_speed_two_param = etls_merge(st_q.preset_speed_two_param, st_q.w_data, st_q.w_strb);
        end
        ETLS_OFF_PRESET_SPEED_THREE: begin
          st_d.preset_speed_three_param = etls_merge(st_q.preset_speed_three_param, st_q.w_data, st_q.w_strb);
        end
        ETLS_OFF_RUN_LEVEL: begin
          st_d.run_level = etls_merge(st_q.run_level, st_q.w_data, st_q.w_strb);
        end
        ETLS_OFF_MONITOR: begin
          st_d.bresp = ETLS_RESP_OKAY;
        end
        default: begin
          st_d.bresp = ETLS_RESP_SLVERR;
        end
      endcase
    end
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end

    // Register read
    if (s_axi_arvalid && s_axi_arready) begin
      st_d.rvalid = 1'b1;
      st_d.rresp  = ETLS_RESP_OKAY;
      st_d.rdata  = 32'h0000_0000;
      case (s_axi_araddr)
        ETLS_OFF_FWD_EXT:   st_d.rdata[15:0] = st_q.forward_external_torque_limit;
        ETLS_OFF_REV_EXT:   st_d.rdata[15:0] = st_q.reverse_external_torque_limit;
        ETLS_OFF_MEM_SW1:   st_d.rdata[15:0] = st_q.memory_switch_one;
        ETLS_OFF_MEM_SW2:   st_d.rdata[15:0] = st_q.memory_switch_two;
        ETLS_OFF_FWD_INT:   st_d.rdata[15:0] = st_q.fwd_int_limit;
        ETLS_OFF_REV_INT:   st_d.rdata[15:0] = st_q.rev_int_limit;
        ETLS_OFF_PRESET_SPEED_ONE:    st_d.rdata[15:0] = st_q.preset_speed_one_param;
        ETLS_OFF_PRESET_SPEED_TWO:    st_d.rdata[15:0] = st_q.preset_speed_two_param;
        ETLS_OFF_PRESET_SPEED_THREE:    st_d.rdata[15:0] = st_q.preset_speed_three_param;
        ETLS_OFF_MONITOR:   st_d.rdata[15:0] = st_q.monitor;
        ETLS_OFF_RUN_LEVEL: st_d.rdata[15:0] = st_q.run_level;
        default:            st_d.rresp = ETLS_RESP_SLVERR;
      endcase
    end
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end

    // Pins limit only when select clear
    // Forward pin high leaves forward free
    fwd_ext = !csel && fwd_on;
    // Reverse pin high leaves reverse free
    rev_ext = !csel && rev_on;

    fwd_eff = fwd_ext ? etls_min(st_q.fwd_int_limit, st_q.forward_external_torque_limit)
                      : st_q.fwd_int_limit;
    rev_eff = rev_ext ? etls_min(st_q.rev_int_limit, st_q.reverse_external_torque_limit)
                      : st_q.rev_int_limit;
    st_d.fwd_lim = fwd_eff;
    st_d.rev_lim = rev_eff;

    tq_mag   = etls_mag(torque_ref);
    limiting = torque_ref[15] ? (tq_mag >= rev_eff) : (tq_mag >= fwd_eff);
    running  = etls_mag(motor_speed) >= st_q.run_level;

    // Status pin and monitor bit 4
    if (st_q.memory_switch_one[ETLS_SW1_LIMIT_OUT_BIT]) begin
      st_d.out_n = !limiting;
    end else begin
      st_d.out_n = !running;
    end
    st_d.monitor = 16'h0000;
    st_d.monitor[ETLS_MON_LIMIT_BIT] = !st_d.out_n;

    code = {fwd_on, rev_on};
    st_d.spd_code = csel ? code : ETLS_CODE_NORMAL;
    st_d.spd_act  = csel && (code != ETLS_CODE_NORMAL);
    unique case (st_d.spd_code)
      ETLS_CODE_SPD1: st_d.spd_ref = st_q.preset_speed_one_param;
      ETLS_CODE_SPD2: st_d.spd_ref = st_q.preset_speed_two_param;
      ETLS_CODE_SPD3: st_d.spd_ref = st_q.preset_speed_three_param;
      default:        st_d.spd_ref = 16'h0000;
    endcase

    st_d.dir_rev = csel && !prop_control_in_n;

    st_d.pctl = !csel && !prop_control_in_n
                && !st_q.memory_switch_one[ETLS_SW1_MODE_A_BIT]
                && !st_q.memory_switch_one[ETLS_SW1_MODE_B_BIT];

    // Bits 7 and 8 follow select
    st_d.monitor[ETLS_MON_SEL1_BIT] = csel ? code[1] : fwd_ext;
    st_d.monitor[ETLS_MON_SEL2_BIT] = csel ? code[0] : rev_ext;
  end

  // ----------------------------------------------------------------
  // State register
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
      st_q.forward_external_torque_limit <= ETLS_RST_EXT_LIMIT;
      st_q.reverse_external_torque_limit <= ETLS_RST_EXT_LIMIT;
      st_q.memory_switch_one <= ETLS_RST_MEM_SW1;
      st_q.memory_switch_two <= ETLS_RST_MEM_SW2;
      st_q.fwd_int_limit <= MAX_TORQUE;
      st_q.rev_int_limit <= MAX_TORQUE;
      st_q.preset_speed_one_param <= ETLS_RST_SPEED;
      st_q.preset_speed_two_param <= ETLS_RST_SPEED;
      st_q.preset_speed_three_param <= ETLS_RST_SPEED;
      st_q.run_level <= ETLS_RST_RUN_LEVEL;
      st_q.fwd_lim <= MAX_TORQUE;
      st_q.rev_lim <= MAX_TORQUE;
      st_q.out_n <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign s_axi_bvalid           = st_q.bvalid;
  assign s_axi_bresp            = st_q.bresp;
  assign s_axi_rvalid           = st_q.rvalid;
  assign s_axi_rdata            = st_q.rdata;
  assign s_axi_rresp            = st_q.rresp;
  assign fwd_torque_limit       = st_q.fwd_lim;
  assign rev_torque_limit       = st_q.rev_lim;
  assign running_or_limit_out_n = st_q.out_n;
  assign p_control_out          = st_q.pctl;
  assign preset_speed_active    = st_q.spd_act;
  assign preset_speed_code      = st_q.spd_code;
  assign preset_speed_ref       = st_q.spd_ref;
  assign speed_dir_rev          = st_q.dir_rev;
  assign monitor_bit_word       = st_q.monitor;

endmodule

// [design/etls_pkg.sv]
// Constants for the external torque limit selector.
// Assumes a 32-bit AXI4-Lite register bus and a 16-bit torque path in percent.
package etls_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] ETLS_OFF_FWD_EXT   = 8'h00;
  localparam logic [7:0] ETLS_OFF_REV_EXT   = 8'h04;
  localparam logic [7:0] ETLS_OFF_MEM_SW1   = 8'h08;
  localparam logic [7:0] ETLS_OFF_MEM_SW2   = 8'h0C;
  localparam logic [7:0] ETLS_OFF_FWD_INT   = 8'h10;
  localparam logic [7:0] ETLS_OFF_REV_INT   = 8'h14;
  localparam logic [7:0] ETLS_OFF_PRESET_SPEED_ONE    = 8'h18;
  localparam logic [7:0] ETLS_OFF_PRESET_SPEED_TWO    = 8'h1C;
  localparam logic [7:0] ETLS_OFF_PRESET_SPEED_THREE    = 8'h20;
  localparam logic [7:0] ETLS_OFF_MONITOR   = 8'h24;
  localparam logic [7:0] ETLS_OFF_RUN_LEVEL = 8'h28;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int ETLS_SW1_LIMIT_OUT_BIT = 4;
  localparam int ETLS_SW1_MODE_A_BIT    = 10;
  localparam int ETLS_SW1_MODE_B_BIT    = 11;
  localparam int ETLS_SW2_CSPEED_BIT    = 2;
  localparam int ETLS_MON_LIMIT_BIT     = 4;
  localparam int ETLS_MON_SEL1_BIT      = 7;
  localparam int ETLS_MON_SEL2_BIT      = 8;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] ETLS_RST_EXT_LIMIT = 16'h0064;
  localparam logic [15:0] ETLS_RST_MEM_SW1   = 16'h0000;
  localparam logic [15:0] ETLS_RST_MEM_SW2   = 16'h0000;
  localparam logic [15:0] ETLS_RST_SPEED     = 16'h0000;
  localparam logic [15:0] ETLS_RST_RUN_LEVEL = 16'h0014;

  // ----------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------
  localparam logic [1:0] ETLS_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ETLS_RESP_SLVERR = 2'h2;
  localparam logic [1:0] ETLS_CODE_NORMAL = 2'h0;
  localparam logic [1:0] ETLS_CODE_SPD1   = 2'h1;
  localparam logic [1:0] ETLS_CODE_SPD2   = 2'h3;
  localparam logic [1:0] ETLS_CODE_SPD3   = 2'h2;

endpackage

// [tb/etls_top_asserts.sv]
// Concurrent checks on the external torque limit selector's ports.
// Assumes binding to etls_top; one clock ref_clk, reset rstn active low.
module etls_top_asserts
  import etls_pkg::*;
#(
  parameter int          TW         = 16,
  parameter logic [15:0] MAX_TORQUE = 16'h012C
) (
  input wire logic          ref_clk,
  input wire logic          rstn,
  input wire logic          s_axi_awvalid,
  input wire logic          s_axi_awready,
  input wire logic          s_axi_wvalid,
  input wire logic          s_axi_wready,
  input wire logic [1:0]    s_axi_bresp,
  input wire logic          s_axi_bvalid,
  input wire logic          s_axi_bready,
  input wire logic          s_axi_arvalid,
  input wire logic          s_axi_arready,
  input wire logic [31:0]   s_axi_rdata,
  input wire logic          s_axi_rvalid,
  input wire logic          s_axi_rready,
  input wire logic          fwd_ext_limit_in_n,
  input wire logic          rev_ext_limit_in_n,
  input wire logic          prop_control_in_n,
  input wire logic [TW-1:0] fwd_torque_limit,
  input wire logic [TW-1:0] rev_torque_limit,
  input wire logic          running_or_limit_out_n,
  input wire logic          p_control_out,
  input wire logic          preset_speed_active,
  input wire logic [1:0]    preset_speed_code,
  input wire logic          speed_dir_rev,
  input wire logic [15:0]   monitor_bit_word
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------
  // Bus handshakes
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rstn);
  sequence ar_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  rd_answer_a: assert property (ar_taken |=> s_axi_rvalid)
    else $error("read data late");
  wr_answer_a: assert property (wr_both |-> ##2 s_axi_bvalid)
    else $error("write response late");
  b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  // ----------------------------------------------------------------
  // Contact decoding and status
  // ----------------------------------------------------------------
  code_pins_a: assert property (preset_speed_code != 2'h0 |-> preset_speed_active &&
    preset_speed_code == {!$past(fwd_ext_limit_in_n), !$past(rev_ext_limit_in_n)})
    else $error("speed code not from pins");
  dir_pin_a: assert property (speed_dir_rev |-> !$past(prop_control_in_n))
    else $error("reverse without input");
  p_pin_a: assert property (p_control_out |-> !$past(prop_control_in_n) && !speed_dir_rev)
    else $error("P control without input");
  mon_status_a: assert property (monitor_bit_word[4] == !running_or_limit_out_n)
    else $error("monitor bit 4 differs from status pin");
  mon_code_a: assert property (preset_speed_active |->
    {monitor_bit_word[7], monitor_bit_word[8]} == preset_speed_code)
    else $error("monitor bits 7/8 differ from code");
  fwd_pin_a: assert property (monitor_bit_word[7] |-> !$past(fwd_ext_limit_in_n))
    else $error("forward limit shown without pin");
  rev_pin_a: assert property (monitor_bit_word[8] |-> !$past(rev_ext_limit_in_n))
    else $error("reverse limit shown without pin");
  cap_max_a: assert property (fwd_torque_limit <= MAX_TORQUE && rev_torque_limit <= MAX_TORQUE)
    else $error("limit above maximum torque");
endmodule

bind etls_top etls_top_asserts #(.TW(TW), .MAX_TORQUE(MAX_TORQUE)) etls_top_asserts_i (
  .ref_clk, .rstn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
  .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .fwd_ext_limit_in_n, .rev_ext_limit_in_n, .prop_control_in_n, .fwd_torque_limit,
  .rev_torque_limit, .running_or_limit_out_n, .p_control_out, .preset_speed_active,
  .preset_speed_code, .speed_dir_rev, .monitor_bit_word);

// [tb/etls_contact_model.sv]
// Contact switches on the far side of the selector.
// Assumes commands change after rising edges; open contacts read high by pull-up.
module etls_contact_model (
  input  wire logic ref_clk,
  input  wire logic rstn,
  input  wire logic fwd_on,
  input  wire logic rev_on,
  input  wire logic prop_on,
  output logic      fwd_ext_limit_in_n,
  output logic      rev_ext_limit_in_n,
  output logic      prop_control_in_n
);
  timeunit 1ns;
  timeprecision 1ps;
  // Closed contact pulls the pin low
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      {fwd_ext_limit_in_n, rev_ext_limit_in_n, prop_control_in_n} <= 3'h7;
    end else begin
      {fwd_ext_limit_in_n, rev_ext_limit_in_n, prop_control_in_n} <= ~{fwd_on, rev_on, prop_on};
    end
  end
endmodule

// [tb/tb.sv]
// Self-checking bench for the external torque limit selector.
// Assumes etls_top with AXI4-Lite registers and the contact switch model.
module tb
  import etls_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [15:0] MAXT = 16'h012C;
  logic        ref_clk, rstn, awvalid, wvalid, bready, arvalid, rready, fon, ron, pon;
  logic        awready, wready, bvalid, arready, rvalid, fpin_n, rpin_n, ppin_n;
  logic        out_n, pctl, pact, dir, e_out_n, e_p, e_dir;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, code, e_code;
  logic [15:0] tref, mspeed, flim, rlim, pref, mon, e_fl, e_rl, e_ref, e_mon;
  logic [15:0] sh [0:10];
  integer      seed = 32'hb677;
  int          miscompares = 0;
  int          n_compared = 0;
  int          cyc = 0;

  etls_top #(.TW(16), .MAX_TORQUE(MAXT)) etls_top_i (
    .ref_clk(ref_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .fwd_ext_limit_in_n(fpin_n),
    .rev_ext_limit_in_n(rpin_n), .prop_control_in_n(ppin_n), .torque_ref(tref), .motor_speed(mspeed),
    .fwd_torque_limit(flim), .rev_torque_limit(rlim), .running_or_limit_out_n(out_n),
    .p_control_out(pctl), .preset_speed_active(pact), .preset_speed_code(code),
    .preset_speed_ref(pref), .speed_dir_rev(dir), .monitor_bit_word(mon));
  etls_contact_model etls_contact_model_i (
    .ref_clk(ref_clk), .rstn(rstn), .fwd_on(fon), .rev_on(ron), .prop_on(pon),
    .fwd_ext_limit_in_n(fpin_n), .rev_ext_limit_in_n(rpin_n), .prop_control_in_n(ppin_n));

  // ----------------------------------------------------------------
  // Clock, timeout and reporting
  // ----------------------------------------------------------------
  always #10 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      miscompares++;
      wrap_up;
    end
  end
  task automatic wrap_up;
    if (miscompares == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s, output logic [1:0] r);
    logic ah, wh, bh;
    bh = 1'b0;
    @(posedge ref_clk);
    {awaddr, wdata, wstrb} <= {a, d, s};
    {awvalid, wvalid, bready} <= 3'h7;
    while (!bh) begin
      @(negedge ref_clk);
      ah = awvalid & awready;
      wh = wvalid & wready;
      bh = bready & bvalid;
      r = bresp;
      @(posedge ref_clk);
      if (ah) awvalid <= 1'b0;
      if (wh) wvalid <= 1'b0;
      if (bh) bready <= 1'b0;
    end
  endtask
  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ah, rh;
    rh = 1'b0;
    @(posedge ref_clk);
    araddr <= a;
    {arvalid, rready} <= 2'h3;
    while (!rh) begin
      @(negedge ref_clk);
      ah = arvalid & arready;
      rh = rready & rvalid;
      {d, r} = {rdata, rresp};
      @(posedge ref_clk);
      if (ah) arvalid <= 1'b0;
      if (rh) rready <= 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // Register shadow and expectations
  // ----------------------------------------------------------------
  function automatic logic [15:0] mn(input logic [15:0] a, input logic [15:0] b);
    return a < b ? a : b;
  endfunction
  function automatic logic [15:0] rv(input int a);
    logic [15:0] v;
    v = 16'($random(seed));
    return a == 2 ? v & 16'h0C10 : a == 3 ? v & 16'h0004 : a == 10 ? v % 16'h00C8 : v % 16'h0190;
  endfunction
  task automatic reg_wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
    logic [1:0]  r;
    logic [15:0] m;
    int          i;
    i = a >> 2;
    bus_wr(a, {16'h0000, d}, s, r);
    if (a <= ETLS_OFF_RUN_LEVEL && i != 9) begin
      m = {s[1] ? d[15:8] : sh[i][15:8], s[0] ? d[7:0] : sh[i][7:0]};
      // Limit clamp
      if ((i < 2 || i == 4 || i == 5) && m > MAXT) m = MAXT;
      sh[i] = m;
    end
    check(32'(r), 32'(a <= ETLS_OFF_RUN_LEVEL ? ETLS_RESP_OKAY : ETLS_RESP_SLVERR));
  endtask
  task automatic reg_rd(input logic [7:0] a);
    logic [1:0]  r;
    logic [31:0] d;
    int          i;
    i = a >> 2;
    bus_rd(a, d, r);
    if (a <= ETLS_OFF_RUN_LEVEL) begin
      check(d, {16'h0000, i == 9 ? e_mon : sh[i]});
      check(32'(r), 32'(ETLS_RESP_OKAY));
    end else begin
      check(d, 32'h0000_0000);
      check(32'(r), 32'(ETLS_RESP_SLVERR));
    end
  endtask
  task automatic calc;
    logic        cs, fa, ra, neg, act;
    logic [15:0] mag, sp;
    cs = sh[3][ETLS_SW2_CSPEED_BIT];
    fa = fon & ~cs;
    ra = ron & ~cs;
    e_fl = fa ? mn(sh[4], sh[0]) : sh[4];
    e_rl = ra ? mn(sh[5], sh[1]) : sh[5];
    neg = tref[15];
    mag = neg ? -tref : tref;
    sp = mspeed[15] ? -mspeed : mspeed;
    act = sh[2][ETLS_SW1_LIMIT_OUT_BIT] ? (mag >= (neg ? e_rl : e_fl)) : (sp >= sh[10]);
    e_code = cs ? {fon, ron} : ETLS_CODE_NORMAL;
    e_ref = e_code == ETLS_CODE_SPD1 ? sh[6] : e_code == ETLS_CODE_SPD2 ? sh[7] :
            e_code == ETLS_CODE_SPD3 ? sh[8] : 16'h0000;
    e_mon = 16'h0000;
    e_mon[ETLS_MON_LIMIT_BIT] = act;
    e_mon[ETLS_MON_SEL1_BIT] = cs ? fon : fa;
    e_mon[ETLS_MON_SEL2_BIT] = cs ? ron : ra;
    e_out_n = ~act;
    e_p = ~cs & pon & (sh[2][11:10] == 2'h0);
    e_dir = cs & pon;
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {ref_clk, rstn, awvalid, wvalid, bready, arvalid, rready, fon, ron, pon} = '0;
    {awaddr, araddr, wdata, wstrb, tref, mspeed} = '0;
    foreach (sh[i]) sh[i] = 16'h0000;
    {sh[0], sh[1], sh[4], sh[5], sh[10]} = {16'h0064, 16'h0064, MAXT, MAXT, 16'h0014};
    repeat (16) @(posedge ref_clk);
    rstn <= 1'b1;
    @(negedge ref_clk);
    calc;
    // Reset values and unmapped place
    for (int a = 0; a < 12; a++) reg_rd(8'(a * 4));
    reg_wr(8'h2C, 16'hFFFF, 4'hF);
    reg_wr(ETLS_OFF_FWD_EXT, 16'hFFFF, 4'h3);
    reg_rd(ETLS_OFF_FWD_EXT);
    for (int k = 0; k < 60; k++) begin
      for (int a = 0; a < 11; a++) reg_wr(8'(a * 4), rv(a), k < 4 ? 4'hF : 4'($random(seed)));
      {fon, ron, pon} <= 3'($random(seed));
      mspeed <= 16'($random(seed) % 300);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      calc;
      @(posedge ref_clk);
      // Torque at exactly the limit every fourth pass
      tref <= k % 4 == 0 ? (k % 8 == 0 ? e_fl : -e_rl) : 16'($random(seed) % 400);
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk);
      calc;
      check(32'(flim), 32'(e_fl));
      check(32'(rlim), 32'(e_rl));
      check(32'(out_n), 32'(e_out_n));
      check(32'(pctl), 32'(e_p));
      check(32'({pact, code, pref}), {13'h0000, e_code != 2'h0, e_code, e_ref});
      check(32'(dir), 32'(e_dir));
      check(32'(mon), 32'(e_mon));
      reg_rd(ETLS_OFF_MONITOR);
    end
    wrap_up;
  end
endmodule
